// ==== design/e1_ovh_pkg.sv ====
// package: register map, field positions, codes and timing counts for the e1 overhead control
package e1_ovh_pkg;
  // register indices as printed, byte address = 4 * index
  localparam logic [11:0] SYNC_MUX_IDX  = 12'h109;
  localparam logic [11:0] ALARM_GEN_IDX = 12'h108;
  localparam logic [11:0] IRQ_STAT_IDX  = 12'h1B0;
  localparam logic [11:0] IRQ_MASK_IDX  = 12'h1B1;
  localparam logic [11:0] RX_STATE_IDX  = 12'h1B2;
  localparam logic [13:0] SYNC_MUX_ADDR  = {SYNC_MUX_IDX, 2'b00};
  localparam logic [13:0] ALARM_GEN_ADDR = {ALARM_GEN_IDX, 2'b00};
  localparam logic [13:0] IRQ_STAT_ADDR  = {IRQ_STAT_IDX, 2'b00};
  localparam logic [13:0] IRQ_MASK_ADDR  = {IRQ_MASK_IDX, 2'b00};
  localparam logic [13:0] RX_STATE_ADDR  = {RX_STATE_IDX, 2'b00};
  // field positions
  localparam int TX_AIS_LSB   = 2;
  localparam int RX_CRIT_LSB  = 0;
  localparam int EBIT_SRC_LSB = 6;
  localparam int FAS_SEL_BIT  = 0;
  localparam logic [7:0] SYNC_MUX_WMASK = 8'hDF;  // bit 5 reserved
  localparam logic [7:0] ALARM_GEN_RST  = 8'h00;
  localparam logic [7:0] SYNC_MUX_RST   = 8'h00;
  // status bits
  localparam int ST_AIS     = 0;
  localparam int ST_SLOT16_ALL_ONES_ALARM   = 1;
  localparam int ST_CRC_ERR = 2;
  // codes
  typedef enum logic [1:0] {
    TX_NORMAL = 2'h0, TX_UNFRAMED = 2'h1, TX_SLOT16 = 2'h2, TX_FRAMED = 2'h3
  } tx_ais_t;
  typedef enum logic [1:0] {
    RX_NEVER = 2'h0, RX_ANY_ONES = 2'h1, RX_SLOT16 = 2'h2, RX_FRAMED_ONLY = 2'h3
  } rx_crit_t;
  typedef enum logic [1:0] {
    EB_CRC = 2'h0, EB_ZERO = 2'h1, EB_ONE = 2'h2, EB_LINK = 2'h3
  } ebit_src_t;
  // frame layout, 32 slots of 8 bits
  localparam logic [4:0] SLOT_FAS = 5'h00;
  localparam logic [4:0] SLOT_16  = 5'h10;
  // consecutive frames to declare and to clear a defect
  localparam logic [1:0] AIS_FRAMES = 2'h3;
  // a frame holds fewer than this many zeros to count as all ones
  localparam logic [8:0] ONES_ZERO_LIMIT = 9'h003;
  localparam logic [4:0] EBIT_BIT_POS = 5'h00;  // bit index of the E bit within slot 0
endpackage

// ==== design/e1_ais_and_ebit_overhead_control.sv ====
// overhead control for one e1 channel: tx ais and e bits, rx ais declaration
`timescale 1ns/10ps
module e1_ais_and_ebit_overhead_control (
  input  wire logic        ref_clk_i,
  input  wire logic        rst_i,
  input  wire logic [13:0] addr_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  output logic      [7:0]  rdata_o,
  output logic             irq_o,
  input  wire logic        tx_data_i,
  input  wire logic [4:0]  tx_slot_i,
  input  wire logic [2:0]  tx_bit_i,
  input  wire logic        tx_ebit_pos_i,
  input  wire logic        tx_link_bit_i,
  output logic             tx_data_o,
  input  wire logic        rx_data_i,
  input  wire logic [4:0]  rx_slot_i,
  input  wire logic [2:0]  rx_bit_i,
  input  wire logic        rx_frame_end_i,
  input  wire logic        rx_in_frame_i,
  input  wire logic        rx_crc_err_i,
  output logic             rx_ais_o,
  output logic             rx_slot16_all_ones_alarm_o
);
  import e1_ovh_pkg::*;

  logic [7:0] alarm_generation_control;
  logic [7:0] sync_mux_and_ebit_control;
  logic [2:0] irq_stat;
  logic [2:0] irq_mask;
  logic       crc_err_seen;
  tx_ais_t    tx_alarm_pattern_select;
  rx_crit_t   rx_alarm_declare_criteria;
  ebit_src_t  ebit_source_select;
  logic       fas_ext;

  assign tx_alarm_pattern_select   = tx_ais_t'(alarm_generation_control[TX_AIS_LSB +: 2]);
  assign rx_alarm_declare_criteria = rx_crit_t'(alarm_generation_control[RX_CRIT_LSB +: 2]);
  assign ebit_source_select        = ebit_src_t'(sync_mux_and_ebit_control[EBIT_SRC_LSB +: 2]);
  assign fas_ext                   = sync_mux_and_ebit_control[FAS_SEL_BIT];

  // register writes; reserved bit 5 is not stored so it reads zero
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      alarm_generation_control  <= ALARM_GEN_RST;
      sync_mux_and_ebit_control <= SYNC_MUX_RST;
      irq_mask                  <= 3'h0;
    end else if (wr_i) begin
      if (addr_i == ALARM_GEN_ADDR) begin
        alarm_generation_control <= {4'h0, wdata_i[3:0]};
      end else if (addr_i == SYNC_MUX_ADDR) begin
        sync_mux_and_ebit_control <= wdata_i & SYNC_MUX_WMASK;
      end else if (addr_i == IRQ_MASK_ADDR) begin
        irq_mask <= wdata_i[2:0];
      end
    end
  end

  // ---------------- transmit path ----------------
  logic next_tx;
  // e bit source first, then the ais pattern over it; e bits only touched when we make the fas ourselves
  always_comb begin
    next_tx = tx_data_i;
    if (tx_ebit_pos_i && !fas_ext) begin
      case (ebit_source_select)
        EB_CRC:  next_tx = ~crc_err_seen;
        EB_ZERO: next_tx = 1'b0;
        EB_ONE:  next_tx = 1'b1;
        default: next_tx = tx_link_bit_i;
      endcase
    end
    case (tx_alarm_pattern_select)
      TX_UNFRAMED: next_tx = 1'b1;
      TX_SLOT16: begin
        if (tx_slot_i == SLOT_16) begin
          next_tx = 1'b1;
        end
      end
      TX_FRAMED: begin
        if (tx_slot_i != SLOT_FAS) begin
          next_tx = 1'b1;
        end
      end
      default: ; // normal traffic passes
    endcase
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tx_data_o <= 1'b1;
    end else begin
      tx_data_o <= next_tx;
    end
  end

  // sticky sub-multiframe crc error flag, one zero e bit however many blocks errored since the last e bit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      crc_err_seen <= 1'b0;
    end else if (rx_crc_err_i) begin
      crc_err_seen <= 1'b1;
    end else if (tx_ebit_pos_i && !fas_ext && ebit_source_select == EB_CRC) begin
      crc_err_seen <= 1'b0; // consumed by one outbound e bit
    end
  end

  // ---------------- receive path ----------------
  // per-frame zero counts: whole frame, payload only, slot 16 only
  logic [8:0] zeros_all;
  logic [8:0] zeros_pay;
  logic [3:0] zeros_16;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i || rx_frame_end_i) begin
      zeros_all <= 9'h000;
      zeros_pay <= 9'h000;
      zeros_16  <= 4'h0;
    end else if (!rx_data_i) begin
      zeros_all <= zeros_all + 9'h001;
      if (rx_slot_i != SLOT_FAS) begin
        zeros_pay <= zeros_pay + 9'h001;
      end
      if (rx_slot_i == SLOT_16) begin
        zeros_16 <= zeros_16 + 4'h1;
      end
    end
  end

  // frame qualifiers evaluated at the frame end; the last bit is counted too
  logic z_last;
  logic frame_unf_ones;
  logic frame_frm_ones;
  logic frame_16_ones;
  assign z_last         = ~rx_data_i;
  assign frame_unf_ones = (zeros_all + {8'h00, z_last}) < ONES_ZERO_LIMIT && !rx_in_frame_i;
  assign frame_frm_ones = (zeros_pay + {8'h00, z_last}) < ONES_ZERO_LIMIT && rx_in_frame_i;
  assign frame_16_ones  = zeros_16 == 4'h0 && !(z_last && rx_slot_i == SLOT_16);

  logic frame_ais_hit;
  always_comb begin
    case (rx_alarm_declare_criteria)
      RX_ANY_ONES:    frame_ais_hit = frame_unf_ones || frame_frm_ones;
      RX_SLOT16:      frame_ais_hit = frame_16_ones;
      RX_FRAMED_ONLY: frame_ais_hit = frame_frm_ones;
      default:        frame_ais_hit = 1'b0;
    endcase
  end

  // hysteresis counters: same frame count to set and to clear
  logic [1:0] ais_cnt;
  logic [1:0] slot16_all_ones_alarm_cnt;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ais_cnt  <= 2'h0;
      rx_ais_o <= 1'b0;
    end else if (rx_alarm_declare_criteria == RX_NEVER) begin
      ais_cnt  <= 2'h0;
      rx_ais_o <= 1'b0;
    end else if (rx_frame_end_i) begin
      if (frame_ais_hit != rx_ais_o) begin
        ais_cnt <= ais_cnt + 2'h1;
        if (ais_cnt == AIS_FRAMES - 2'h1) begin
          rx_ais_o <= frame_ais_hit;
          ais_cnt  <= 2'h0;
        end
      end else begin
        ais_cnt <= 2'h0;
      end
    end
  end

  // slot 16 ais is watched regardless of the criteria field
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      slot16_all_ones_alarm_cnt  <= 2'h0;
      rx_slot16_all_ones_alarm_o <= 1'b0;
    end else if (rx_frame_end_i) begin
      if (frame_16_ones != rx_slot16_all_ones_alarm_o) begin
        slot16_all_ones_alarm_cnt <= slot16_all_ones_alarm_cnt + 2'h1;
        if (slot16_all_ones_alarm_cnt == AIS_FRAMES - 2'h1) begin
          rx_slot16_all_ones_alarm_o <= frame_16_ones;
          slot16_all_ones_alarm_cnt  <= 2'h0;
        end
      end else begin
        slot16_all_ones_alarm_cnt <= 2'h0;
      end
    end
  end

  // edge events for the sticky status
  logic ais_q;
  logic slot16_all_ones_alarm_q;
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ais_q   <= 1'b0;
      slot16_all_ones_alarm_q <= 1'b0;
    end else begin
      ais_q   <= rx_ais_o;
      slot16_all_ones_alarm_q <= rx_slot16_all_ones_alarm_o;
    end
  end

  logic [2:0] events;
  // bit positions come from the package so the status layout lives in one place
  always_comb begin
    events             = 3'h0;
    events[ST_AIS]     = rx_ais_o ^ ais_q;
    events[ST_SLOT16_ALL_ONES_ALARM]   = rx_slot16_all_ones_alarm_o ^ slot16_all_ones_alarm_q;
    events[ST_CRC_ERR] = rx_crc_err_i;
  end

  // read clears the status; a same-cycle event still sets its bit
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_stat <= 3'h0;
    end else if (rd_i && addr_i == IRQ_STAT_ADDR) begin
      irq_stat <= events;
    end else begin
      irq_stat <= irq_stat | events;
    end
  end

  // status as it stands after this edge, so irq_o lags a new event by one cycle only
  logic [2:0] next_stat_w;
  assign next_stat_w = (rd_i && addr_i == IRQ_STAT_ADDR) ? events : (irq_stat | events);

  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(next_stat_w & irq_mask);
    end
  end

  // read data one cycle after the strobe, zero for unmapped addresses
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (rd_i) begin
      if (addr_i == ALARM_GEN_ADDR) begin
        rdata_o <= alarm_generation_control;
      end else if (addr_i == SYNC_MUX_ADDR) begin
        rdata_o <= sync_mux_and_ebit_control;
      end else if (addr_i == IRQ_STAT_ADDR) begin
        rdata_o <= {5'h00, irq_stat};
      end else if (addr_i == IRQ_MASK_ADDR) begin
        rdata_o <= {5'h00, irq_mask};
      end else if (addr_i == RX_STATE_ADDR) begin
        rdata_o <= {6'h00, rx_slot16_all_ones_alarm_o, rx_ais_o};
      end else begin
        rdata_o <= 8'h00;
      end
    end else begin
      rdata_o <= 8'h00;
    end
  end

  // ---------------- checks ----------------
  // transmit side: ais pattern forcing and pass-through of everything it leaves alone
  a_unframed_ones: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_UNFRAMED)
    |=> tx_data_o)
    else $error("unframed ais not all ones");
  a_slot16_force: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_SLOT16 && tx_slot_i == SLOT_16)
    |=> tx_data_o)
    else $error("slot 16 ais not all ones");
  a_slot16_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_SLOT16 && tx_slot_i != SLOT_16 && !tx_ebit_pos_i)
    |=> tx_data_o == $past(tx_data_i))
    else $error("slot 16 ais touched another slot");
  a_framed_keep: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_FRAMED && tx_slot_i == SLOT_FAS && !tx_ebit_pos_i)
    |=> tx_data_o == $past(tx_data_i))
    else $error("framed ais overwrote framing");
  a_framed_payload: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_FRAMED && tx_slot_i != SLOT_FAS)
    |=> tx_data_o)
    else $error("framed ais payload not all ones");
  a_normal_pass: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_NORMAL && !tx_ebit_pos_i)
    |=> tx_data_o == $past(tx_data_i))
    else $error("normal traffic altered");

  // e bit source; only honoured while this side makes the alignment pattern
  a_ebit_zero: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_NORMAL && tx_ebit_pos_i && !fas_ext
     && ebit_source_select == EB_ZERO)
    |=> !tx_data_o)
    else $error("e bit not zero");
  a_ebit_one: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_NORMAL && tx_ebit_pos_i && !fas_ext
     && ebit_source_select == EB_ONE)
    |=> tx_data_o)
    else $error("e bit not one");
  a_ebit_link: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_NORMAL && tx_ebit_pos_i && !fas_ext
     && ebit_source_select == EB_LINK)
    |=> tx_data_o == $past(tx_link_bit_i))
    else $error("e bit not carrying link data");
  // an error two cycles before an e bit slot, with no e bit slot in between, must show up as a zero e bit
  a_ebit_crc_err: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_crc_err_i ##1 !tx_ebit_pos_i ##1 (tx_alarm_pattern_select == TX_NORMAL
     && tx_ebit_pos_i && !fas_ext && ebit_source_select == EB_CRC)
    |=> !tx_data_o)
    else $error("crc error not reported in e bit");
  a_ebit_fas_ext: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (tx_alarm_pattern_select == TX_NORMAL && fas_ext)
    |=> tx_data_o == $past(tx_data_i))
    else $error("e bit changed with external framing");

  // receive side: the defect only moves at frame ends, or clears at once under criteria 00, and only for qualifying patterns
  a_never_declare: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_alarm_declare_criteria == RX_NEVER)
    |=> !rx_ais_o)
    else $error("ais declared with criteria 00");
  a_framed_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_alarm_declare_criteria == RX_FRAMED_ONLY && rx_frame_end_i
     && !rx_in_frame_i && !rx_ais_o)
    |=> !rx_ais_o)
    else $error("unframed frame counted toward framed ais");
  a_slot16_only: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (rx_alarm_declare_criteria == RX_SLOT16 && rx_frame_end_i
     && zeros_16 != 4'h0 && !rx_ais_o)
    |=> !rx_ais_o)
    else $error("slot 16 ais declared with zeros in slot 16");
  a_ais_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!rx_frame_end_i && rx_alarm_declare_criteria != RX_NEVER)
    |=> $stable(rx_ais_o))
    else $error("ais changed outside frame end");
  a_slot16_all_ones_alarm_hold: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (!rx_frame_end_i)
    |=> $stable(rx_slot16_all_ones_alarm_o))
    else $error("slot 16 ais changed outside frame end");

  // status, interrupt and read port; a set in the clearing cycle must survive
  a_stat_crc: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    rx_crc_err_i
    |=> irq_stat[ST_CRC_ERR])
    else $error("crc error status not set");
  a_stat_sticky: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !(rd_i && addr_i == IRQ_STAT_ADDR)
    |=> (irq_stat & $past(irq_stat)) == $past(irq_stat))
    else $error("status bit lost without a read");
  a_irq_masked: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    (irq_mask == 3'h0)
    |=> !irq_o)
    else $error("interrupt raised while fully masked");
  a_irq_follow: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    ((|(irq_stat & irq_mask)) && !(rd_i && addr_i == IRQ_STAT_ADDR))
    |=> irq_o)
    else $error("interrupt low with unmasked status");
  a_rdata_idle: assert property (@(posedge ref_clk_i) disable iff (rst_i)
    !rd_i
    |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");

  // main scenarios that the bench is expected to reach
  c_tx_framed: cover property (@(posedge ref_clk_i) tx_alarm_pattern_select == TX_FRAMED);
  c_ais_set: cover property (@(posedge ref_clk_i) $rose(rx_ais_o));
  c_ais_clear: cover property (@(posedge ref_clk_i) $fell(rx_ais_o));
  c_slot16_all_ones_alarm_set: cover property (@(posedge ref_clk_i) $rose(rx_slot16_all_ones_alarm_o));
  c_irq: cover property (@(posedge ref_clk_i) $rose(irq_o));
endmodule

// ==== test/e1_line_model.sv ====
// remote e1 line terminal model: sends receive frames of a chosen pattern
`timescale 1ns/10ps
module e1_line_model (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [1:0] pat_i,
  output logic            data_o,
  output logic [4:0]      slot_o,
  output logic [2:0]      bit_o,
  output logic            frame_end_o,
  output logic            in_frame_o
);
  logic [7:0] cnt;
  logic       fas;
  // 256 bit frame position, slot and bit index follow it
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= 8'h00;
    end else begin
      cnt <= cnt + 8'h01;
    end
  end
  assign slot_o = cnt[7:3];
  assign bit_o = cnt[2:0];
  assign frame_end_o = (cnt == 8'hFF);
  // slot 0 alternates so a framed pattern never looks unframed
  assign fas = (slot_o == 5'h00) & cnt[0];
  // pattern 0 idle traffic, 1 unframed ones, 2 slot 16 ones, 3 framed ones
  always_comb begin
    case (pat_i)
      2'h1: data_o = 1'b1;
      2'h2: data_o = (slot_o == 5'h10);
      2'h3: data_o = (slot_o != 5'h00) | fas;
      default: data_o = fas;
    endcase
  end
  assign in_frame_o = (pat_i != 2'h1);  // unframed ones costs alignment
endmodule

// ==== test/e1_ais_and_ebit_overhead_control_tb.sv ====
// self-checking bench for the e1 overhead control block
`timescale 1ns/10ps
module e1_ais_and_ebit_overhead_control_tb;
  import e1_ovh_pkg::*;
  logic        ref_clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [13:0] addr_i = 14'h0000;
  logic [7:0]  wdata_i = 8'h00;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        tx_data_i = 1'b0;
  logic [4:0]  tx_slot_i = 5'h00;
  logic        tx_epos = 1'b0;
  logic        tx_link = 1'b0;
  logic        rx_crc_err_i = 1'b0;
  logic [1:0]  pat = 2'h0;
  logic [7:0]  rdata_o;
  logic [7:0]  rv;
  logic [4:0]  rx_slot;
  logic [2:0]  rx_bit;
  logic        irq_o, tx_data_o, rx_data, rx_fe, rx_inf, rx_ais_o, rx_slot16_all_ones_alarm_o;
  int          n_errors = 0;
  int          compares = 0;

  e1_ais_and_ebit_overhead_control dut (
    .ref_clk_i(ref_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .irq_o(irq_o),
    .tx_data_i(tx_data_i), .tx_slot_i(tx_slot_i), .tx_bit_i(3'h0),
    .tx_ebit_pos_i(tx_epos), .tx_link_bit_i(tx_link), .tx_data_o(tx_data_o),
    .rx_data_i(rx_data), .rx_slot_i(rx_slot), .rx_bit_i(rx_bit),
    .rx_frame_end_i(rx_fe), .rx_in_frame_i(rx_inf), .rx_crc_err_i(rx_crc_err_i),
    .rx_ais_o(rx_ais_o), .rx_slot16_all_ones_alarm_o(rx_slot16_all_ones_alarm_o)
  );
  e1_line_model line (
    .clk_i(ref_clk_i), .rst_i(rst_i), .pat_i(pat), .data_o(rx_data),
    .slot_o(rx_slot), .bit_o(rx_bit), .frame_end_o(rx_fe), .in_frame_o(rx_inf)
  );

  initial begin
    forever #4 ref_clk_i = ~ref_clk_i;
  end

  task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
    compares++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr(input logic [13:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    wr_i <= 1'b1; addr_i <= a; wdata_i <= d;
    @(posedge ref_clk_i);
    wr_i <= 1'b0;
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [13:0] a);
    @(posedge ref_clk_i);
    rd_i <= 1'b1; addr_i <= a;
    @(posedge ref_clk_i);
    rd_i <= 1'b0;
    #1 rv = rdata_o;
  endtask
  task automatic txc(input logic [4:0] s, input logic d, e, l, x, input string w);
    @(posedge ref_clk_i);
    tx_slot_i <= s; tx_data_i <= d; tx_epos <= e; tx_link <= l;
    @(posedge ref_clk_i);
    #1 chk(w, 8'(x), 8'(tx_data_o));
  endtask
  // pattern starts on a frame boundary; two frames must not yet flip the state
  task automatic phase(input logic [1:0] p, input logic eb, ea, e16);
    @(posedge ref_clk_i iff rx_fe === 1'b1);
    pat <= p;
    repeat (516) @(posedge ref_clk_i);
    #1 chk("ais early", 8'(eb), 8'(rx_ais_o));
    repeat (256) @(posedge ref_clk_i);
    #1 chk("ais", 8'(ea), 8'(rx_ais_o));
    chk("slot16_all_ones_alarm", 8'(e16), 8'(rx_slot16_all_ones_alarm_o));
  endtask

  task automatic t_regs;
    rd(ALARM_GEN_ADDR); chk("alarm gen reset", 8'h00, rv);
    rd(SYNC_MUX_ADDR); chk("sync mux reset", 8'h00, rv);
    wr(SYNC_MUX_ADDR, 8'hFF);
    rd(SYNC_MUX_ADDR); chk("sync mux rw", 8'hDF, rv);
    wr(ALARM_GEN_ADDR, 8'h0F);
    rd(ALARM_GEN_ADDR); chk("alarm gen rw", 8'h0F, rv);
    rd(14'h0010); chk("unmapped", 8'h00, rv);
  endtask
  task automatic t_tx;
    for (int m = 0; m < 4; m++) begin
      wr(ALARM_GEN_ADDR, 8'(m << 2));
      txc(5'h05, 1'b0, 1'b0, 1'b0, m[0], "tx payload");
      txc(5'h10, 1'b0, 1'b0, 1'b0, m != 0, "tx slot16");
      txc(5'h00, 1'b0, 1'b0, 1'b0, m == 1, "tx slot0");
    end
    wr(ALARM_GEN_ADDR, 8'h00);
  endtask
  task automatic t_ebit;
    for (int s = 1; s < 4; s++) begin
      wr(SYNC_MUX_ADDR, 8'(s << 6));
      txc(5'h00, s != 2, 1'b1, 1'b0, s == 2, "ebit const");
    end
    txc(5'h00, 1'b0, 1'b1, 1'b1, 1'b1, "ebit link");
    wr(SYNC_MUX_ADDR, 8'h41);
    txc(5'h00, 1'b1, 1'b1, 1'b0, 1'b1, "ebit external fas");
    wr(SYNC_MUX_ADDR, 8'h00);
    txc(5'h00, 1'b0, 1'b1, 1'b0, 1'b1, "ebit crc clean");
    // park the e bit position so the pending error is not used up early
    @(posedge ref_clk_i);
    rx_crc_err_i <= 1'b1;
    tx_epos      <= 1'b0;
    @(posedge ref_clk_i);
    rx_crc_err_i <= 1'b0;
    txc(5'h00, 1'b1, 1'b1, 1'b0, 1'b0, "ebit crc error");
    txc(5'h00, 1'b0, 1'b1, 1'b0, 1'b1, "ebit crc after");
    rd(IRQ_STAT_ADDR); chk("crc status", 8'h04, rv & 8'h04);
    rd(IRQ_STAT_ADDR); chk("crc status cleared", 8'h00, rv & 8'h04);
  endtask
  task automatic t_rx;
    logic e;
    for (int c = 0; c < 4; c++) begin
      wr(ALARM_GEN_ADDR, 8'(c));
      for (int p = 1; p < 4; p++) begin
        e = (c == 1 && p != 2) || c == 2 || (c == 3 && p == 3);
        phase(2'(p), 1'b0, e, 1'b1);
        phase(2'h0, e, 1'b0, 1'b0);
      end
    end
  endtask
  // unmasked status drives the level interrupt until a status read
  task automatic t_irq;
    wr(IRQ_MASK_ADDR, 8'h00);
    wr(ALARM_GEN_ADDR, 8'h01);
    phase(2'h1, 1'b0, 1'b1, 1'b1);
    chk("irq masked", 8'h00, 8'(irq_o));
    rd(RX_STATE_ADDR); chk("alarm state", 8'h03, rv);
    wr(IRQ_MASK_ADDR, 8'h01);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("irq raised", 8'h01, 8'(irq_o));
    rd(IRQ_MASK_ADDR); chk("irq mask rw", 8'h01, rv);
    rd(IRQ_STAT_ADDR); chk("ais status", 8'h01, rv & 8'h01);
    repeat (2) @(posedge ref_clk_i);
    #1 chk("irq cleared", 8'h00, 8'(irq_o));
    wr(IRQ_MASK_ADDR, 8'h00);
    phase(2'h0, 1'b1, 1'b0, 1'b0);
  endtask

  task automatic report_and_stop;
    $display("mismatches %0d of %0d compares", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // whole run is about 27k cycles, so 60k cycles means a hang
  initial begin
    #480000;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (3) @(posedge ref_clk_i);
    rst_i <= 1'b0;
    t_regs();
    t_tx();
    t_ebit();
    t_rx();
    t_irq();
    report_and_stop();
  end
endmodule
